// ### src/cmf_defines.svh
// constants for the chained math function block: offsets, fields, resets
// assumes Q16.16 signed fixed point, 1.0 standing for 100 percent
//
// Summary of operation
// - four math blocks, four selectable inputs each
// - inputs normalised between own minimum and maximum
// - normalised input times weight, default 1.0
// - codes 0-5 compare operand_a with operand_b
// - codes 6, 7, 8 give OR, AND, XOR
// - codes 9-14 sum, difference, product, quotient, min, max
// - function 1 uses inputs 1 and 2
// - function 2 uses result 1 and input 3
// - function 3 uses result 2 and input 4
// - own-block input may take a function result
// - unused input 3 or 4 skips function 2 or 3 onward, earlier result outputs; unused input 1 or 2 makes the block unavailable
// - logic operand true at or above one half
// - codes 0-8 yield exactly 0 or 1
// - error input enters as zero
// - divide by zero operand yields zero
// - negative difference clamps unless negative weighting
// - final percent mapped between output limits
// - output limits normalise this block elsewhere
// - input limits default zero, within ten thousand
`ifndef CMF_DEFINES_SVH
`define CMF_DEFINES_SVH

// ==========================================
// sizes
`define CMF_NBLK 4
`define CMF_NIN 4
`define CMF_NEXT 8
`define CMF_AW 12

// ==========================================
// fixed point figures
`define CMF_ONE 32'sh00010000
`define CMF_HALF 32'sh00008000
`define CMF_LIM 32'sh27100000
`define CMF_OMAX_RST 32'sh00640000
`define CMF_OMIN_RST 32'sh00000000
`define CMF_ILIM_RST 32'sh00000000
`define CMF_SCL_RST 32'sh00010000
`define CMF_OPS_RST 12'h000

// ==========================================
// register offsets within a block window
`define CMF_OFF_CTRL 8'h00
`define CMF_OFF_OPS 8'h04
`define CMF_OFF_OMIN 8'h08
`define CMF_OFF_OMAX 8'h0C
`define CMF_OFF_RES 8'h10
`define CMF_OFF_STAT 8'h14
`define CMF_OFF_PCT 8'h18
`define CMF_OFF_IN 8'h40
`define CMF_FLD_SRC 2'h0
`define CMF_FLD_MIN 2'h1
`define CMF_FLD_MAX 2'h2
`define CMF_FLD_SCL 2'h3

// ==========================================
// field positions
`define CMF_EN_BIT 0
`define CMF_SRC_LSB 0
`define CMF_FN_LSB 8
`define CMF_AVAIL_BIT 0

// ==========================================
// source codes
`define CMF_SRC_NONE 4'h0
`define CMF_SRC_EXT0 4'h1
`define CMF_SRC_MATH0 4'h9
`define CMF_SRC_MATHL 4'hC

`endif

// ### src/cmf_pkg.sv
// types shared by the chained math function block
// assumes cmf_defines.svh is on the include path
`default_nettype none
package cmf_pkg;
   typedef struct packed
   {
      logic avail;
      logic err;
      logic signed [31:0] value;
   } cmf_sig_type;

   typedef enum logic [3:0]
   {
      OP_EQ = 4'h0, OP_NE = 4'h1, OP_GT = 4'h2, OP_GE = 4'h3,
      OP_LT = 4'h4, OP_LE = 4'h5, OP_OR = 4'h6, OP_AND = 4'h7,
      OP_XOR = 4'h8, OP_ADD = 4'h9, OP_SUB = 4'hA, OP_MUL = 4'hB,
      OP_DIV = 4'hC, OP_MIN = 4'hD, OP_MAX = 4'hE
   } cmf_op_type;

   typedef enum logic {ST_NORM, ST_CALC} cmf_state_type;
endpackage
`default_nettype wire

// ### src/cmf_top.sv
// four chained math blocks with an apb register slave
// assumes signals from other blocks are synchronous to pclk
`timescale 1ns/1ps
`default_nettype none
`include "cmf_defines.svh"
module cmf_top
   import cmf_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`CMF_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // signals from other function blocks
   input wire cmf_sig_type sig_in [`CMF_NEXT],
   // math block outputs
   output cmf_sig_type blk_out [`CMF_NBLK]
);

   // ==========================================
   // arithmetic helpers
   function automatic logic signed [31:0] sat1(input logic signed [63:0] x);
      logic signed [63:0] y;
      y = x;
      if (x > 64'(`CMF_ONE))
         y = 64'(`CMF_ONE);
      else if (x < -64'(`CMF_ONE))
         y = -64'(`CMF_ONE);
      return y[31:0];
   endfunction

   function automatic logic signed [31:0] lim(input logic signed [31:0] x);
      logic signed [31:0] y;
      y = x;
      if (x > `CMF_LIM)
         y = `CMF_LIM;
      else if (x < -`CMF_LIM)
         y = -`CMF_LIM;
      return y;
   endfunction

   function automatic logic signed [31:0] fix_mul(input logic signed [31:0] a,
      input logic signed [31:0] b);
      logic signed [63:0] p;
      p = 64'(a) * 64'(b);
      return sat1(p >>> 16);
   endfunction

   // zero span gives zero: a default input with both limits at 0 is inert
   function automatic logic signed [31:0] norm(input logic signed [31:0] x,
      input logic signed [31:0] lo, input logic signed [31:0] hi);
      logic signed [63:0] den;
      logic signed [63:0] q;
      den = 64'(hi) - 64'(lo);
      q = 64'sh0;
      if (den != 64'sh0)
         q = ((64'(x) - 64'(lo)) <<< 16) / den;
      if (q < 64'sh0)
         q = 64'sh0;
      return sat1(q);
   endfunction

   function automatic logic signed [31:0] apply_op(input cmf_op_type op,
      input logic signed [31:0] a, input logic signed [31:0] b,
      input logic neg_ok);
      logic ta;
      logic tb;
      logic t;
      logic is_log;
      logic signed [63:0] w;
      ta = a >= `CMF_HALF;
      tb = b >= `CMF_HALF;
      t = 1'b0;
      is_log = 1'b1;
      w = 64'sh0;
      case (op)
         OP_EQ: t = a == b;
         OP_NE: t = a != b;
         OP_GT: t = a > b;
         OP_GE: t = a >= b;
         OP_LT: t = a < b;
         OP_LE: t = a <= b;
         OP_OR: t = ta | tb;
         OP_AND: t = ta & tb;
         OP_XOR: t = ta ^ tb;
         OP_ADD:
         begin
            is_log = 1'b0;
            w = 64'(a) + 64'(b);
         end
         OP_SUB:
         begin
            is_log = 1'b0;
            w = 64'(a) - 64'(b);
            if (w < 64'sh0 && !neg_ok)
               w = 64'sh0;
         end
         OP_MUL:
         begin
            is_log = 1'b0;
            w = (64'(a) * 64'(b)) >>> 16;
         end
         OP_DIV:
         begin
            is_log = 1'b0;
            if (b != 32'sh0)
               w = (64'(a) <<< 16) / 64'(b);
            else
               w = 64'sh0;
         end
         OP_MIN:
         begin
            is_log = 1'b0;
            w = (a < b) ? 64'(a) : 64'(b);
         end
         OP_MAX:
         begin
            is_log = 1'b0;
            w = (a > b) ? 64'(a) : 64'(b);
         end
         default: is_log = 1'b0;
      endcase
      // saturation covers configurations that leave full scale
      if (is_log)
         return t ? `CMF_ONE : 32'sh0;
      return sat1(w);
   endfunction

   function automatic logic addr_ok(input logic [`CMF_AW-1:0] a);
      logic [7:0] o;
      o = a[7:0];
      return a[11:10] == 2'h0 && o[1:0] == 2'h0 &&
         (o <= `CMF_OFF_PCT || o >= `CMF_OFF_IN);
   endfunction

   // ==========================================
   // configuration and result state
   logic en_r [`CMF_NBLK];
   logic [11:0] ops_r [`CMF_NBLK];
   logic signed [31:0] omin_r [`CMF_NBLK];
   logic signed [31:0] omax_r [`CMF_NBLK];
   logic [3:0] src_r [`CMF_NBLK][`CMF_NIN];
   logic [1:0] fn_r [`CMF_NBLK][`CMF_NIN];
   logic signed [31:0] imin_r [`CMF_NBLK][`CMF_NIN];
   logic signed [31:0] imax_r [`CMF_NBLK][`CMF_NIN];
   logic signed [31:0] scl_r [`CMF_NBLK][`CMF_NIN];
   logic signed [31:0] pct_r [`CMF_NBLK];
   logic signed [31:0] fres_r [`CMF_NBLK][3];
   cmf_sig_type out_r [`CMF_NBLK];

   // ==========================================
   // apb slave, one wait state so read data comes from a flop
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic [31:0] rd_nxt;
   logic wr_go;
   logic [1:0] ab;
   logic [1:0] ai;
   logic [7:0] ao;

   assign ab = paddr[9:8];
   assign ao = paddr[7:0];
   assign ai = ao[5:4];
   assign wr_go = psel && penable && pwrite && pready_r && addr_ok(paddr);

   always_comb
   begin
      rd_nxt = 32'h0;
      if (ao >= `CMF_OFF_IN)
      begin
         case (ao[3:2])
            `CMF_FLD_SRC:
            begin
               rd_nxt[`CMF_SRC_LSB +: 4] = src_r[ab][ai];
               rd_nxt[`CMF_FN_LSB +: 2] = fn_r[ab][ai];
            end
            `CMF_FLD_MIN: rd_nxt = imin_r[ab][ai];
            `CMF_FLD_MAX: rd_nxt = imax_r[ab][ai];
            default: rd_nxt = scl_r[ab][ai];
         endcase
      end
      else
      begin
         case (ao)
            `CMF_OFF_CTRL: rd_nxt[`CMF_EN_BIT] = en_r[ab];
            `CMF_OFF_OPS: rd_nxt[11:0] = ops_r[ab];
            `CMF_OFF_OMIN: rd_nxt = omin_r[ab];
            `CMF_OFF_OMAX: rd_nxt = omax_r[ab];
            `CMF_OFF_RES: rd_nxt = out_r[ab].value;
            `CMF_OFF_STAT: rd_nxt[`CMF_AVAIL_BIT] = out_r[ab].avail;
            `CMF_OFF_PCT: rd_nxt = pct_r[ab];
            default: rd_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0;
      end
      else
      begin
         pready_r <= psel && penable && !pready_r;
         pslverr_r <= psel && penable && !pready_r && !addr_ok(paddr);
         if (psel && penable && !pready_r && !pwrite && addr_ok(paddr))
            prdata_r <= rd_nxt;
      end
   end

   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign prdata = prdata_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int b = 0; b < `CMF_NBLK; b++)
         begin
            en_r[b] <= 1'b0;
            ops_r[b] <= `CMF_OPS_RST;
            omin_r[b] <= `CMF_OMIN_RST;
            omax_r[b] <= `CMF_OMAX_RST;
            for (int i = 0; i < `CMF_NIN; i++)
            begin
               src_r[b][i] <= `CMF_SRC_NONE;
               fn_r[b][i] <= 2'h0;
               imin_r[b][i] <= `CMF_ILIM_RST;
               imax_r[b][i] <= `CMF_ILIM_RST;
               scl_r[b][i] <= `CMF_SCL_RST;
            end
         end
      end
      else if (wr_go)
      begin
         if (ao >= `CMF_OFF_IN)
         begin
            case (ao[3:2])
               `CMF_FLD_SRC:
               begin
                  src_r[ab][ai] <= pwdata[`CMF_SRC_LSB +: 4];
                  fn_r[ab][ai] <= pwdata[`CMF_FN_LSB +: 2];
               end
               `CMF_FLD_MIN: imin_r[ab][ai] <= lim(pwdata);
               `CMF_FLD_MAX: imax_r[ab][ai] <= lim(pwdata);
               default: scl_r[ab][ai] <= sat1(64'($signed(pwdata)));
            endcase
         end
         else
         begin
            case (ao)
               `CMF_OFF_CTRL: en_r[ab] <= pwdata[`CMF_EN_BIT];
               `CMF_OFF_OPS: ops_r[ab] <= pwdata[11:0];
               `CMF_OFF_OMIN: omin_r[ab] <= lim(pwdata);
               `CMF_OFF_OMAX: omax_r[ab] <= lim(pwdata);
               default: ;
            endcase
         end
      end
   end

   // ==========================================
   // sequencer: blocks are served in turn, two cycles each
   cmf_state_type state_r;
   logic [1:0] idx_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r <= ST_NORM;
         idx_r <= 2'h0;
      end
      else
      begin
         case (state_r)
            ST_NORM: state_r <= ST_CALC;
            ST_CALC:
            begin
               state_r <= ST_NORM;
               idx_r <= idx_r + 2'h1;
            end
            default: state_r <= ST_NORM;
         endcase
      end
   end

   // ==========================================
   // operand stage
   logic signed [31:0] opn_c [`CMF_NIN];
   logic used_c [`CMF_NIN];
   logic negw_c [`CMF_NIN];
   logic signed [31:0] opn_r [`CMF_NIN];
   logic used_r [`CMF_NIN];
   logic negw_r [`CMF_NIN];

   always_comb
   begin
      logic [3:0] s;
      logic [1:0] m;
      logic [1:0] f;
      logic signed [31:0] raw;
      cmf_sig_type e;
      s = 4'h0;
      m = 2'h0;
      f = 2'h0;
      raw = 32'sh0;
      e = '0;
      for (int j = 0; j < `CMF_NIN; j++)
      begin
         s = src_r[idx_r][j];
         f = fn_r[idx_r][j];
         raw = 32'sh0;
         used_c[j] = 1'b0;
         if (s >= `CMF_SRC_EXT0 && s < `CMF_SRC_MATH0)
         begin
            used_c[j] = 1'b1;
            e = sig_in[3'(s - `CMF_SRC_EXT0)];
            if (e.avail && !e.err)
               raw = norm(e.value, imin_r[idx_r][j], imax_r[idx_r][j]);
         end
         else if (s >= `CMF_SRC_MATH0 && s <= `CMF_SRC_MATHL)
         begin
            used_c[j] = 1'b1;
            m = 2'(s - `CMF_SRC_MATH0);
            // stored percent equals renormalising by the output limits
            if (m == idx_r && f != 2'h0)
               raw = fres_r[idx_r][f - 2'h1];
            else if (out_r[m].avail)
               raw = pct_r[m];
         end
         opn_c[j] = fix_mul(raw, scl_r[idx_r][j]);
         negw_c[j] = scl_r[idx_r][j] < 32'sh0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int j = 0; j < `CMF_NIN; j++)
         begin
            opn_r[j] <= 32'sh0;
            used_r[j] <= 1'b0;
            negw_r[j] <= 1'b0;
         end
      end
      else if (state_r == ST_NORM)
      begin
         opn_r <= opn_c;
         used_r <= used_c;
         negw_r <= negw_c;
      end
   end

   // ==========================================
   // function chain and output scaling
   logic ok1;
   logic ok2;
   logic ok3;
   logic n1;
   logic n2;
   logic n3;
   cmf_op_type op1;
   cmf_op_type op2;
   cmf_op_type op3;
   logic signed [31:0] r1;
   logic signed [31:0] r2;
   logic signed [31:0] r3;
   logic signed [31:0] fin;
   logic signed [63:0] phys;

   assign ok1 = used_r[0] && used_r[1];
   assign ok2 = ok1 && used_r[2];
   assign ok3 = ok2 && used_r[3];
   assign n1 = negw_r[0] || negw_r[1];
   assign n2 = n1 || negw_r[2];
   assign n3 = n2 || negw_r[3];
   assign op1 = cmf_op_type'(ops_r[idx_r][3:0]);
   assign op2 = cmf_op_type'(ops_r[idx_r][7:4]);
   assign op3 = cmf_op_type'(ops_r[idx_r][11:8]);
   assign r1 = apply_op(op1, opn_r[0], opn_r[1], n1);
   assign r2 = apply_op(op2, r1, opn_r[2], n2);
   assign r3 = apply_op(op3, r2, opn_r[3], n3);
   assign fin = ok3 ? r3 : (ok2 ? r2 : r1);
   assign phys = 64'(omin_r[idx_r]) + (((64'(omax_r[idx_r]) -
      64'(omin_r[idx_r])) * 64'(fin)) >>> 16);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int b = 0; b < `CMF_NBLK; b++)
         begin
            pct_r[b] <= 32'sh0;
            out_r[b] <= '0;
            for (int k = 0; k < 3; k++)
               fres_r[b][k] <= 32'sh0;
         end
      end
      else if (state_r == ST_CALC)
      begin
         if (en_r[idx_r] && ok1)
         begin
            fres_r[idx_r][0] <= r1;
            fres_r[idx_r][1] <= ok2 ? r2 : 32'sh0;
            fres_r[idx_r][2] <= ok3 ? r3 : 32'sh0;
            pct_r[idx_r] <= fin;
            out_r[idx_r].avail <= 1'b1;
            out_r[idx_r].err <= 1'b0;
            out_r[idx_r].value <= phys[31:0];
         end
         else
         begin
            out_r[idx_r] <= '0;
            pct_r[idx_r] <= 32'sh0;
         end
      end
   end

   assign blk_out = out_r;

   // ==========================================
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   apb_wait_one_a: assert property (psel && penable && !pready |=> pready)
      else $error("apb answer not after one wait state");
   apb_ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   apb_unmapped_a: assert property (psel && penable && pready &&
      !addr_ok(paddr) |-> pslverr)
      else $error("unmapped address not flagged");
   disabled_na_a: assert property (
      state_r == ST_CALC && !en_r[idx_r]
      |=> !blk_out[$past(idx_r)].avail)
      else $error("disabled block reports available");
   logic_bool_a: assert property (
      state_r == ST_CALC && en_r[idx_r] && ok1 && op1 <= OP_XOR
      |=> fres_r[$past(idx_r)][0] == 32'sh0 ||
      fres_r[$past(idx_r)][0] == `CMF_ONE)
      else $error("logic result not 0 or 1");
   div_zero_a: assert property (
      state_r == ST_CALC && en_r[idx_r] && ok1 &&
      op1 == OP_DIV && opn_r[1] == 32'sh0
      |=> fres_r[$past(idx_r)][0] == 32'sh0)
      else $error("division by zero not zero");
   sub_clamp_a: assert property (
      state_r == ST_CALC && en_r[idx_r] && ok1 && op1 == OP_SUB && !n1
      |=> fres_r[$past(idx_r)][0] >= 32'sh0)
      else $error("negative difference not clamped");
   out_scale_a: assert property (
      state_r == ST_CALC && en_r[idx_r] && ok1 && fin == 32'sh0
      |=> blk_out[$past(idx_r)].value == $past(omin_r[idx_r]))
      else $error("zero percent not at output minimum");
   // input 2 on source 2 is the path that the bench puts in error
   err_zero_a: assert property (
      state_r == ST_NORM && src_r[idx_r][1] == `CMF_SRC_EXT0 + 4'h1 &&
      sig_in[1].err |=> opn_r[1] == 32'sh0)
      else $error("error input not taken as zero");
   skip_fn_a: assert property (
      state_r == ST_CALC && en_r[idx_r] && ok1 && !ok2
      |=> pct_r[$past(idx_r)] == $past(r1))
      else $error("skipped function changed output");

endmodule
`default_nettype wire

// ### dv/cmf_src_model.sv
// partner model: the function blocks that feed the math blocks
// assumes it shares pclk with the math blocks, changes after an edge
`timescale 1ns/1ps
`default_nettype none
`include "cmf_defines.svh"
module cmf_src_model
   import cmf_pkg::*;
(
   // clock
   input wire logic pclk,
   // signals toward the math blocks
   output var cmf_sig_type sig_out [`CMF_NEXT]
);
   // ==========================================
   // source state
   initial
   begin
      foreach (sig_out[i])
      begin
         sig_out[i] = '{1'b0, 1'b0, 32'h0};
      end
   end

   // sources only move right after a clock edge, as a real block does
   task automatic put(input int idx, input logic ok, input logic bad,
      input logic [31:0] v);
      @(posedge pclk);
      sig_out[idx] <= '{ok, bad, v};
   endtask
endmodule
`default_nettype wire

// ### dv/tb.sv
// testbench: apb master and scenarios for the chained math blocks
// assumes cmf_src_model stands in for the feeding function blocks
`timescale 1ns/1ps
`default_nettype none
`include "cmf_defines.svh"
module tb
   import cmf_pkg::*;
   ;
   // ==========================================
   // signals
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [`CMF_AW-1:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   cmf_sig_type sig_in [`CMF_NEXT];
   cmf_sig_type blk_out [`CMF_NBLK];
   int error_cnt = 0;
   int num_checks = 0;
   logic [31:0] rd_d;
   logic rd_e;
   localparam logic [31:0] HUND = 32'h00640000;

   cmf_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .sig_in, .blk_out);
   cmf_src_model src_u (.pclk, .sig_out(sig_in));

   // ==========================================
   // helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string m);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd_d = prdata;
      rd_e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] e,
      input string m);
      apb(1'b0, a, 32'h0);
      chk(rd_d, e, m);
      chk({31'h0, rd_e}, 32'h0, m);
   endtask

   task automatic inp(input int b, input int i, input logic [31:0] src,
      input logic [31:0] mn, input logic [31:0] mx);
      logic [11:0] a;
      a = 12'(b * 256 + i * 16 + 64);
      wr(a, src);
      wr(a + 12'h004, mn);
      wr(a + 12'h008, mx);
   endtask

   // the eval loop refreshes within 10 cycles, so 12 is settled
   task automatic out_is(input int b, input logic av, input logic [31:0] v,
      input string m);
      repeat (12) @(posedge pclk);
      chk({31'h0, blk_out[b].avail}, {31'h0, av}, m);
      chk({31'h0, blk_out[b].err}, 32'h0, m);
      chk(blk_out[b].value, v, m);
   endtask

   function automatic logic [31:0] phys(input logic signed [31:0] p,
      input logic signed [31:0] lo, input logic signed [31:0] hi);
      logic signed [63:0] t;
      logic signed [63:0] s;
      t = p;
      s = hi - lo;
      t = t * s;
      return lo + t[47:16];
   endfunction

   // ==========================================
   // scenarios
   task automatic t_reset();
      rdc(12'h008, 32'h0, "omin rst");
      rdc(12'h30C, HUND, "omax rst blk3");
      rdc(12'h04C, 32'h00010000, "scl rst");
      rdc(12'h044, 32'h0, "min rst");
      rdc(12'h078, 32'h0, "max rst");
      wr(12'h044, 32'h7FFF0000);
      rdc(12'h044, `CMF_LIM, "min clamp");
      wr(12'h044, 32'h0);
      apb(1'b0, 12'h400, 32'h0);
      chk({31'h0, rd_e}, 32'h1, "unmapped");
      out_is(3, 1'b0, 32'h0, "blk3 off");
      out_is(2, 1'b0, 32'h0, "blk2 off");
   endtask

   // a = 0.5 sits exactly on the logic threshold, b = 0.25 below it
   // code 15 has no operation and gives 0
   task automatic t_ops();
      logic [31:0] tab [16];
      tab = '{32'h0, 32'h10000, 32'h10000, 32'h10000, 32'h0, 32'h0,
         32'h10000, 32'h0, 32'h10000, 32'hC000, 32'h4000, 32'h2000,
         32'h10000, 32'h4000, 32'h8000, 32'h0};
      src_u.put(0, 1'b1, 1'b0, 32'h00320000);
      src_u.put(1, 1'b1, 1'b0, 32'h00190000);
      inp(0, 0, 32'h1, 32'h0, HUND);
      inp(0, 1, 32'h2, 32'h0, HUND);
      wr(12'h000, 32'h1);
      for (int k = 0; k < 16; k++)
      begin
         wr(12'h004, 32'(k));
         out_is(0, 1'b1, phys(tab[k], 32'h0, HUND), "op");
         rdc(12'h018, tab[k], "pct");
      end
   endtask

   // f1 add 0.75, f2 minus 0.5, f3 times 1.0, out range 10..30
   task automatic t_chain();
      src_u.put(2, 1'b1, 1'b0, 32'h00280000);
      src_u.put(3, 1'b1, 1'b0, HUND);
      inp(0, 2, 32'h3, 32'h00140000, 32'h003C0000);
      inp(0, 3, 32'h4, 32'h0, HUND);
      wr(12'h008, 32'h000A0000);
      wr(12'h00C, 32'h001E0000);
      wr(12'h004, 32'h00000BA9);
      out_is(0, 1'b1, 32'h000F0000, "chain");
      rdc(12'h010, 32'h000F0000, "res rd");
      rdc(12'h014, 32'h1, "stat rd");
      wr(12'h070, 32'h00000109);
      out_is(0, 1'b1, 32'h000DC000, "own f1");
      wr(12'h070, 32'h00000209);
      out_is(0, 1'b1, 32'h000B4000, "own f2");
      wr(12'h070, 32'h0);
      out_is(0, 1'b1, 32'h000F0000, "skip f3");
      wr(12'h060, 32'h0);
      out_is(0, 1'b1, 32'h00190000, "skip f2");
      inp(1, 0, 32'h9, 32'h0, 32'h0);
      inp(1, 1, 32'h1, 32'h0, 32'h0);
      wr(12'h104, 32'h0000000E);
      wr(12'h100, 32'h1);
      out_is(1, 1'b1, 32'h004B0000, "from blk0");
   endtask

   task automatic t_edge();
      src_u.put(1, 1'b1, 1'b0, 32'h0);
      wr(12'h004, 32'h0000000C);
      out_is(0, 1'b1, 32'h000A0000, "div zero");
      src_u.put(1, 1'b1, 1'b1, 32'h00190000);
      wr(12'h004, 32'h00000009);
      out_is(0, 1'b1, 32'h00140000, "err in");
      src_u.put(1, 1'b1, 1'b0, 32'h004B0000);
      wr(12'h004, 32'h0000000A);
      out_is(0, 1'b1, 32'h000A0000, "sub clamp");
      wr(12'h04C, 32'hFFFF8000);
      out_is(0, 1'b1, 32'hFFF60000, "neg weight");
      wr(12'h040, 32'h0);
      repeat (12) @(posedge pclk);
      chk({31'h0, blk_out[0].avail}, 32'h0, "in1 unused");
      wr(12'h000, 32'h0);
      out_is(0, 1'b0, 32'h0, "disabled");
   endtask

   // ==========================================
   // verdict, clock, sequence, watchdog
   task automatic give_verdict();
      if (error_cnt == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_ops();
      t_chain();
      t_edge();
      give_verdict();
   end

   // whole run needs about 700 cycles
   initial
   begin
      repeat (10000) @(posedge pclk);
      error_cnt++;
      give_verdict();
   end
endmodule
`default_nettype wire
